// File: logic/clkgen_defines.svh
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

`define ADDR_W            4
`define DATA_W            8
`define REG_LOOP_CTRL     4'h0
`define REG_IRQ_STATUS    4'h1
`define REG_IRQ_CLEAR     4'h2
`define REG_IRQ_ENABLE    4'h3
`define REG_GEN_STATE     4'h4
`define CTRL_BCS_BIT      0
`define CTRL_LOOP_ON_BIT  1
`define CTRL_AUTO_BIT     2
`define CTRL_FLAG_BIT     3
`define CTRL_LOCKIE_BIT   4
`define IRQ_LOCK_BIT      0
`define IRQ_STOP_BIT      1
`define IRQ_W             2
`define STATE_STOPPED_BIT 0
`define STATE_LOCK_BIT    1
`define STATE_OSC_BIT     2
`define STATE_LOOP_BIT    3
`define ZERO8             8'h00
`define ZERO2             2'h0

`endif

// File: logic/clkgen_pkg.sv
package clkgen_pkg;

  typedef enum logic [1:0] {
    RUN_ST  = 2'b00,
    STOP_ST = 2'b01
  } gen_state_type;

endpackage : clkgen_pkg

// File: logic/clkgen_status_if.sv
`timescale 1ns/1ps
`default_nettype none

interface clkgen_status_if;
  logic       lock;
  logic       stopped;
  logic [1:0] events;
  modport src (output lock, output stopped, output events);
  modport dst (input lock, input stopped, input events);
endinterface : clkgen_status_if

`default_nettype wire

// File: logic/clk_half_div.sv
`timescale 1ns/1ps
`default_nettype none

// Halves a clock rate as a one-cycle enable; phase cleared while gated
module clk_half_div (
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  input  wire logic run_in,
  input  wire logic tick_in,
  output var  logic half_tick_out
);
  typedef struct packed {
    logic phase;
    logic half;
  } div_state_type;

  div_state_type st_ff;
  div_state_type nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.half = 1'b0;
    if (!run_in) begin
      nxt_st.phase = 1'b0;
    end else if (tick_in) begin
      nxt_st.phase = ~st_ff.phase;
      nxt_st.half  = st_ff.phase;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign half_tick_out = st_ff.half;
endmodule : clk_half_div

`default_nettype wire

// File: logic/lock_watch.sv
`timescale 1ns/1ps
`default_nettype none

// Synchronises the loop lock indicator and reports each change
module lock_watch (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       lock_pin_in,
  input  wire logic       stop_req_in,
  input  wire logic       stopped_in,
  clkgen_status_if.src    stat
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic last;
  } watch_state_type;

  watch_state_type st_ff;
  watch_state_type nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.s1   = lock_pin_in;
    nxt_st.s2   = st_ff.s1;
    nxt_st.last = st_ff.s2;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stat.lock    = st_ff.s2;
  assign stat.stopped = stopped_in;
  assign stat.events  = {stop_req_in, st_ff.s2 ^ st_ff.last};
endmodule : lock_watch

`default_nettype wire

// File: logic/clock_generator_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_defines.svh"

// How it works
// - Stop with option clear kills oscillator, loop
// - Stopped, option clear: all clock outputs low
// - Stop on loop source clears select bit
// - After stop, crystal half drives base
// - Option set: stop kills loop only
// - Break clears need break_clear_enable set
// - Break-time clears persist after break
// - Enable clear: control access in break keeps flag
// - Select bit picks loop or crystal half
// - Auto mode: lock change sets flag
module clock_generator_unit (
  input  wire logic                 ref_clk_in,
  input  wire logic                 rstn_in,
  input  wire logic                 xtal_tick_in,
  input  wire logic                 vco_tick_in,
  input  wire logic                 lock_pin_in,
  input  wire logic                 stop_in,
  input  wire logic                 wake_in,
  input  wire logic                 break_in,
  input  wire logic                 break_clear_enable_in,
  input  wire logic                 osc_run_in_stop_enable_in,
  input  wire logic [`ADDR_W-1:0]   addr_in,
  input  wire logic [`DATA_W-1:0]   wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output var  logic [`DATA_W-1:0]   rdata_out,
  output var  logic                 crystal_clock_out,
  output var  logic                 base_clock_out,
  output var  logic                 gen_interrupt_clock_out,
  output var  logic                 osc_enable_out,
  output var  logic                 loop_enable_out,
  output var  logic                 irq_out
);
  typedef struct packed {
    clkgen_pkg::gen_state_type gst;
    logic                      s1_stop;
    logic                      s2_stop;
    logic                      s1_wake;
    logic                      s2_wake;
    logic                      s1_brk;
    logic                      s2_brk;
    logic                      s1_break_clear_enable;
    logic                      s2_break_clear_enable;
    logic                      s1_oscen;
    logic                      s2_oscen;
    logic                      prev_stop;
    logic                      base_clock_select;
    logic                      loop_on;
    logic                      auto_bw;
    logic                      lock_flag;
    logic                      lock_ie;
    logic [`IRQ_W-1:0]         irq_stat;
    logic [`IRQ_W-1:0]         irq_en;
    logic [`DATA_W-1:0]        rdata;
    logic                      xclk;
    logic                      bclk;
    logic                      iclk;
    logic                      osc_en;
    logic                      loop_en;
    logic                      irq;
  } gen_reg_type;

  gen_reg_type st_ff;
  gen_reg_type nxt_st;

  logic                 xtal_half;
  logic                 vco_half;
  logic                 stop_edge;
  logic                 osc_live;
  logic                 loop_live;
  clkgen_status_if      stat ();

  // Status clear allowed outside break, or in break when enabled
  function automatic logic clear_ok(input logic brk, input logic break_clear_enable);
    clear_ok = !brk || break_clear_enable;
  endfunction : clear_ok

  function automatic logic hit(input logic stb, input logic [`ADDR_W-1:0] a,
                               input logic [`ADDR_W-1:0] r);
    hit = stb && (a == r);
  endfunction : hit

  assign stop_edge = st_ff.s2_stop && !st_ff.prev_stop;
  assign osc_live  = (st_ff.gst == clkgen_pkg::RUN_ST) || st_ff.s2_oscen;
  assign loop_live = (st_ff.gst == clkgen_pkg::RUN_ST) && st_ff.loop_on;

  clk_half_div u_xdiv (
    .ref_clk_in    (ref_clk_in),
    .rstn_in       (rstn_in),
    .run_in        (osc_live),
    .tick_in       (xtal_tick_in),
    .half_tick_out (xtal_half)
  );

  clk_half_div u_vdiv (
    .ref_clk_in    (ref_clk_in),
    .rstn_in       (rstn_in),
    .run_in        (loop_live),
    .tick_in       (vco_tick_in),
    .half_tick_out (vco_half)
  );

  lock_watch u_lock (
    .ref_clk_in  (ref_clk_in),
    .rstn_in     (rstn_in),
    .lock_pin_in (lock_pin_in),
    .stop_req_in (stop_edge),
    .stopped_in  (st_ff.gst == clkgen_pkg::STOP_ST),
    .stat        (stat.src)
  );

  always_comb begin
    logic                 may_clr;
    logic [`IRQ_W-1:0]    ev;
    logic [`IRQ_W-1:0]    clr;
    nxt_st    = st_ff;
    may_clr   = clear_ok(st_ff.s2_brk, st_ff.s2_break_clear_enable);
    ev        = stat.events;
    clr       = `ZERO2;
    nxt_st.s1_stop  = stop_in;
    nxt_st.s2_stop  = st_ff.s1_stop;
    nxt_st.s1_wake  = wake_in;
    nxt_st.s2_wake  = st_ff.s1_wake;
    nxt_st.s1_brk   = break_in;
    nxt_st.s2_brk   = st_ff.s1_brk;
    nxt_st.s1_break_clear_enable  = break_clear_enable_in;
    nxt_st.s2_break_clear_enable  = st_ff.s1_break_clear_enable;
    nxt_st.s1_oscen = osc_run_in_stop_enable_in;
    nxt_st.s2_oscen = st_ff.s1_oscen;
    nxt_st.prev_stop = st_ff.s2_stop;
    nxt_st.rdata     = `ZERO8;

    // Register writes
    if (hit(wr_in, addr_in, `REG_LOOP_CTRL)) begin
      nxt_st.base_clock_select     = wdata_in[`CTRL_BCS_BIT];
      nxt_st.loop_on = wdata_in[`CTRL_LOOP_ON_BIT];
      nxt_st.auto_bw = wdata_in[`CTRL_AUTO_BIT];
      nxt_st.lock_ie = wdata_in[`CTRL_LOCKIE_BIT];
      // Flag is write-zero-to-clear; blocked in protected break
      if (!wdata_in[`CTRL_FLAG_BIT] && may_clr) begin
        nxt_st.lock_flag = 1'b0;
      end
    end
    if (hit(wr_in, addr_in, `REG_IRQ_CLEAR) && may_clr) begin
      clr = wdata_in[`IRQ_W-1:0];
    end
    if (hit(wr_in, addr_in, `REG_IRQ_ENABLE)) begin
      nxt_st.irq_en = wdata_in[`IRQ_W-1:0];
    end

    // Events win over a same-cycle clear
    if (st_ff.auto_bw && ev[`IRQ_LOCK_BIT]) begin
      nxt_st.lock_flag = 1'b1;
    end
    nxt_st.irq_stat = (st_ff.irq_stat & ~clr) |
                      {ev[`IRQ_STOP_BIT], ev[`IRQ_LOCK_BIT] && st_ff.auto_bw};

    // Stop sequencing
    unique case (st_ff.gst)
      clkgen_pkg::RUN_ST: begin
        if (stop_edge) begin
          nxt_st.gst = clkgen_pkg::STOP_ST;
          nxt_st.base_clock_select = 1'b0;
        end
      end
      clkgen_pkg::STOP_ST: begin
        nxt_st.base_clock_select = 1'b0;
        if (st_ff.s2_wake) begin
          nxt_st.gst = clkgen_pkg::RUN_ST;
        end
      end
      default: nxt_st.gst = clkgen_pkg::RUN_ST;
    endcase

    // Reads: plain reads never touch the flag
    if (rd_in) begin
      unique case (addr_in)
        `REG_LOOP_CTRL: begin
          nxt_st.rdata[`CTRL_BCS_BIT]     = st_ff.base_clock_select;
          nxt_st.rdata[`CTRL_LOOP_ON_BIT] = st_ff.loop_on;
          nxt_st.rdata[`CTRL_AUTO_BIT]    = st_ff.auto_bw;
          nxt_st.rdata[`CTRL_FLAG_BIT]    = st_ff.lock_flag && st_ff.auto_bw;
          nxt_st.rdata[`CTRL_LOCKIE_BIT]  = st_ff.lock_ie;
        end
        `REG_IRQ_STATUS: nxt_st.rdata[`IRQ_W-1:0] = st_ff.irq_stat;
        `REG_IRQ_ENABLE: nxt_st.rdata[`IRQ_W-1:0] = st_ff.irq_en;
        `REG_GEN_STATE: begin
          nxt_st.rdata[`STATE_STOPPED_BIT] = stat.stopped;
          nxt_st.rdata[`STATE_LOCK_BIT]    = stat.lock && st_ff.auto_bw;
          nxt_st.rdata[`STATE_OSC_BIT]     = st_ff.osc_en;
          nxt_st.rdata[`STATE_LOOP_BIT]    = st_ff.loop_en;
        end
        default: nxt_st.rdata = `ZERO8;
      endcase
    end

    // Clock outputs; stopped with option clear forces all low
    nxt_st.osc_en  = osc_live;
    nxt_st.loop_en = loop_live;
    nxt_st.xclk    = osc_live && xtal_tick_in;
    nxt_st.iclk    = osc_live && xtal_tick_in;
    nxt_st.bclk    = (st_ff.gst == clkgen_pkg::RUN_ST) &&
                     (st_ff.base_clock_select ? vco_half : xtal_half);
    nxt_st.irq     = |(st_ff.irq_stat & st_ff.irq_en) ||
                     (st_ff.lock_ie && st_ff.lock_flag && st_ff.auto_bw);
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_out               = st_ff.rdata;
  assign crystal_clock_out       = st_ff.xclk;
  assign base_clock_out          = st_ff.bclk;
  assign gen_interrupt_clock_out = st_ff.iclk;
  assign osc_enable_out          = st_ff.osc_en;
  assign loop_enable_out         = st_ff.loop_en;
  assign irq_out                 = st_ff.irq;
endmodule : clock_generator_unit

`default_nettype wire

// File: verification/clkgen_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_defines.svh"

module clkgen_monitor (
  input wire logic              ref_clk_in,
  input wire logic              rstn_in,
  input wire logic              xtal_tick_in,
  input wire logic              stop_in,
  input wire logic              wake_in,
  input wire logic              osc_run_in_stop_enable_in,
  input wire logic              rd_in,
  input wire logic [`DATA_W-1:0] rdata_out,
  input wire logic              crystal_clock_out,
  input wire logic              base_clock_out,
  input wire logic              gen_interrupt_clock_out,
  input wire logic              osc_enable_out,
  input wire logic              loop_enable_out,
  input wire logic              irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == `ZERO8)
    else $error("read data outside its answer cycle");
  a_int_clock_copy: assert property (gen_interrupt_clock_out == crystal_clock_out)
    else $error("interrupt clock differs from crystal clock");
  a_clock_needs_tick: assert property (crystal_clock_out |-> $past(xtal_tick_in))
    else $error("crystal clock pulse without a tick");
  a_dead_osc_quiet: assert property (!osc_enable_out [*2] |-> !crystal_clock_out && !base_clock_out)
    else $error("clock output active with oscillator off");
  a_osc_drop_loop: assert property ($fell(osc_enable_out) |-> !loop_enable_out)
    else $error("oscillator stopped while loop still on");
  a_stop_loop_off: assert property ($rose(stop_in) && !wake_in |-> ##[1:8] !loop_enable_out)
    else $error("loop still on after stop");
  a_stop_osc_off: assert property (
    $rose(stop_in) && !wake_in && !osc_run_in_stop_enable_in |-> ##[1:8] !osc_enable_out)
    else $error("oscillator still on after stop");
  a_option_keeps_osc: assert property (osc_run_in_stop_enable_in [*4] |-> !$fell(osc_enable_out))
    else $error("oscillator stopped with run option set");

  c_loop_stop: cover property ($fell(loop_enable_out));
  c_osc_stop: cover property ($fell(osc_enable_out));
  c_irq_raise: cover property ($rose(irq_out));
endmodule : clkgen_monitor

bind clock_generator_unit clkgen_monitor i_mon (.ref_clk_in, .rstn_in, .xtal_tick_in,
  .stop_in, .wake_in, .osc_run_in_stop_enable_in, .rd_in, .rdata_out, .crystal_clock_out,
  .base_clock_out, .gen_interrupt_clock_out, .osc_enable_out, .loop_enable_out, .irq_out);

`default_nettype wire

// File: verification/cpu_sim_model.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_sim_model (
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  input  wire logic stop_req_in,
  input  wire logic wake_req_in,
  input  wire logic brk_req_in,
  input  wire logic bce_req_in,
  output var  logic stop_out,
  output var  logic wake_out,
  output var  logic break_out,
  output var  logic break_clear_enable_out
);
  // Clear-enable leaves reset at 0 so break-time access guards the flag
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stop_out               <= 1'h0;
      wake_out               <= 1'h0;
      break_out              <= 1'h0;
      break_clear_enable_out <= 1'h0;
    end else begin
      stop_out               <= stop_req_in;
      wake_out               <= wake_req_in;
      break_out              <= brk_req_in;
      break_clear_enable_out <= bce_req_in;
    end
  end
endmodule : cpu_sim_model

`default_nettype wire

// File: verification/pll_clock_stop_break_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module pll_clock_stop_break_control_test;
  logic       clk, rstn, xtal, vco, lock, opt, wr, rd, cclk, bclk, iclk, osc_en, loop_en, irq;
  logic       stop_r, wake_r, brk_r, bce_r, stop_w, wake_w, brk_w, bce_w;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, cnt, d;
  int         failures, comparisons, nx, nb;

  cpu_sim_model i_cpu (.ref_clk_in(clk), .rstn_in(rstn), .stop_req_in(stop_r),
    .wake_req_in(wake_r), .brk_req_in(brk_r), .bce_req_in(bce_r), .stop_out(stop_w),
    .wake_out(wake_w), .break_out(brk_w), .break_clear_enable_out(bce_w));

  clock_generator_unit i_dut (.ref_clk_in(clk), .rstn_in(rstn), .xtal_tick_in(xtal),
    .vco_tick_in(vco), .lock_pin_in(lock), .stop_in(stop_w), .wake_in(wake_w),
    .break_in(brk_w), .break_clear_enable_in(bce_w), .osc_run_in_stop_enable_in(opt),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .crystal_clock_out(cclk), .base_clock_out(bclk), .gen_interrupt_clock_out(iclk),
    .osc_enable_out(osc_en), .loop_enable_out(loop_en), .irq_out(irq));

  // Crystal tick every 8 cycles, loop tick every 2
  always @(posedge clk) begin
    cnt  <= cnt + 8'h01;
    xtal <= (cnt[2:0] == 3'h7);
    vco  <= cnt[0];
  end

  task summarize;
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'h1;
    @(posedge clk);
    wr    <= 1'h0;
  endtask : wr_reg

  task rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd   <= 1'h0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg

  task wait_en(input logic [1:0] want, input logic [1:0] mask);
    int i;
    for (i = 0; i < 40 && (({osc_en, loop_en} & mask) !== want); i++) @(negedge clk);
    if (i == 40) begin
      failures++;
      $display("[ERR] %0t enable wait timed out", $time);
      summarize();
    end
  endtask : wait_en

  task count_clk;
    nx = 0;
    nb = 0;
    repeat (64) begin
      @(negedge clk);
      if (cclk === 1'h1) nx++;
      if (bclk === 1'h1) nb++;
    end
  endtask : count_clk

  task sc_select;
    wr_reg(4'h0, 8'h03);
    repeat (4) @(posedge clk);
    count_clk();
    chk(8'(nb), 8'h10);
    wr_reg(4'h0, 8'h02);
    repeat (4) @(posedge clk);
    count_clk();
    chk(8'(nb), 8'h04);
    chk(8'(nx), 8'h08);
  endtask : sc_select

  task sc_stop(input logic o);
    @(posedge clk);
    opt <= o;
    wr_reg(4'h0, 8'h03);
    repeat (8) @(posedge clk);
    stop_r <= 1'h1;
    wait_en({o, 1'h0}, 2'h3);
    count_clk();
    chk(8'(nb), 8'h00);
    chk(8'(nx), o ? 8'h08 : 8'h00);
    rd_reg(4'h0);
    chk(d & 8'h01, 8'h00);
    @(posedge clk);
    stop_r <= 1'h0;
    wake_r <= 1'h1;
    // Loop coming back on marks the return to run in both option settings
    wait_en(2'h1, 2'h1);
    @(posedge clk);
    wake_r <= 1'h0;
    opt    <= 1'h0;
    repeat (4) @(posedge clk);
    count_clk();
    chk(8'(nb), 8'h04);
    rd_reg(4'h0);
    chk(d & 8'h01, 8'h00);
  endtask : sc_stop

  task sc_break;
    wr_reg(4'h0, 8'h06);
    lock <= 1'h1;
    repeat (8) @(posedge clk);
    rd_reg(4'h0);
    chk(d & 8'h08, 8'h08);
    @(posedge clk);
    brk_r <= 1'h1;
    repeat (6) @(posedge clk);
    wr_reg(4'h0, 8'h06);
    wr_reg(4'h2, 8'h01);
    rd_reg(4'h0);
    chk(d & 8'h08, 8'h08);
    rd_reg(4'h1);
    chk(d & 8'h01, 8'h01);
    @(posedge clk);
    bce_r <= 1'h1;
    repeat (6) @(posedge clk);
    wr_reg(4'h0, 8'h06);
    wr_reg(4'h2, 8'h01);
    rd_reg(4'h0);
    chk(d & 8'h08, 8'h00);
    @(posedge clk);
    brk_r <= 1'h0;
    bce_r <= 1'h0;
    repeat (6) @(posedge clk);
    rd_reg(4'h0);
    chk(d & 8'h08, 8'h00);
    rd_reg(4'h1);
    chk(d & 8'h01, 8'h00);
  endtask : sc_break

  task sc_irq;
    @(posedge clk);
    lock <= 1'h0;
    repeat (8) @(posedge clk);
    wr_reg(4'h3, 8'h00);
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    wr_reg(4'h3, 8'h01);
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    wr_reg(4'h2, 8'h01);
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    rd_reg(4'hF);
    chk(d, 8'h00);
  endtask : sc_irq

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  initial begin
    {rstn, lock, opt, wr, rd, stop_r, wake_r, brk_r, bce_r} = 9'h000;
    {xtal, vco} = 2'h0;
    addr = 4'h0;
    wdata = 8'h00;
    cnt = 8'h00;
    failures = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    rd_reg(4'h0);
    chk(d, 8'h00);
    sc_select();
    sc_stop(1'h0);
    sc_stop(1'h1);
    sc_break();
    sc_irq();
    summarize();
  end
endmodule : pll_clock_stop_break_control_test

`default_nettype wire
